// file: rtl/dpbank_debounce.sv
// debounce filter for one digital input
`timescale 1ns/1ns
`default_nettype none
module dpbank_debounce #(
    parameter int UNIT_CYCLES = dpbank_pkg::DEBOUNCE_UNIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        unit_tick,
    input  wire logic [15:0] debounce_units,
    input  wire logic        raw_in,
    output logic             clean_out
);
    logic [15:0] held_units_ff;

    // level accepted after debounce_units unit ticks while steady, which can be up to one unit short of full time
    always_ff @(posedge mclk) begin
        if (srst) begin
            clean_out     <= 1'b0;
            held_units_ff <= 16'h0000;
        end else if (raw_in == clean_out) begin
            held_units_ff <= 16'h0000; // short pulse discarded, see RULE13
        end else if (held_units_ff >= debounce_units) begin
            clean_out     <= raw_in; // see RULE13
            held_units_ff <= 16'h0000;
        end else if (unit_tick) begin
            held_units_ff <= held_units_ff + 16'h0001; // see RULE10
        end
    end
endmodule
`default_nettype wire

// file: rtl/dpbank_pkg.sv
// shared constants and carrier types for the drive parameter bank
`default_nettype none
package dpbank_pkg;

    // ==========================================================
    // register offsets (documented addresses)
    localparam logic [11:0] OFS_SPEED_INTEGRAL   = 12'h20c;
    localparam logic [11:0] OFS_SPEED_FEEDFWD    = 12'h20e;
    localparam logic [11:0] OFS_SPECIAL_FUNCTION = 12'h210;
    localparam logic [11:0] OFS_DEBOUNCE         = 12'h212;
    localparam logic [11:0] OFS_INPUT1_SELECT    = 12'h214;
    localparam logic [11:0] OFS_PROTECTED_COMM   = 12'h414;
    localparam logic [11:0] OFS_PROT_BLOCK_FIRST = 12'h416;
    localparam logic [11:0] OFS_PROT_BLOCK_LAST  = 12'h426;
    localparam logic [11:0] OFS_PASSWORD         = 12'h500;

    // ==========================================================
    // reset values and ranges
    localparam logic [15:0] RST_SPEED_INTEGRAL = 16'h0064;
    localparam logic [15:0] RST_SPEED_FEEDFWD  = 16'h0000;
    localparam logic [15:0] RST_SPECIAL_FUNC   = 16'h0000;
    localparam logic [15:0] RST_DEBOUNCE       = 16'h0002;
    localparam logic [15:0] RST_INPUT1_SELECT  = 16'h0101;
    localparam logic [15:0] RST_PROTECTED      = 16'h0000;
    localparam logic [15:0] MAX_SPEED_INTEGRAL = 16'h03ff;
    localparam logic [15:0] MAX_SPEED_FEEDFWD  = 16'h0064;
    localparam logic [15:0] MAX_DEBOUNCE       = 16'h0014;
    localparam logic [15:0] MAX_INPUT_SELECT   = 16'h015f;
    localparam logic [15:0] MAX_PASSWORD       = 16'h0000 + 16'd65535;
    localparam int          PASSWORD_DIGITS    = 5;

    // ==========================================================
    // command codes
    localparam logic [15:0] CMD_PARAM_RESET   = 16'h000a;
    localparam logic [15:0] CMD_UNLOCK_COMM   = 16'h0014;
    localparam logic [15:0] CMD_UNLOCK_BLOCK  = 16'h0016;
    localparam logic [15:0] CMD_FORCE_OUTPUTS = 16'h0196;
    localparam logic [15:0] CMD_NORMAL_OUTPUT = 16'h0190;

    // ==========================================================
    // selector fields
    localparam int SEL_POLARITY_BIT = 8;
    localparam int SEL_FUNC_MSB     = 7;

    // ==========================================================
    // timing
    localparam int CLK_MHZ          = 250;
    localparam int DEBOUNCE_UNIT_US = 2000;
    localparam int DEBOUNCE_UNIT_CYCLES = DEBOUNCE_UNIT_US * CLK_MHZ;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [15:0] data;
    } dpbank_write_type;

    typedef struct packed {
        logic        accepted;
        logic        refused;
    } dpbank_wresp_type;

endpackage
`default_nettype wire

// file: rtl/dpbank_top.sv
// drive parameter bank with command word, password lock and debounced input
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1: command 10 marks all parameters for default restore, applied at the next power-up.
// RULE2: command 20 opens writes to the protected communication parameter.
// RULE3: command 22 opens writes to the nine protected parameters after it.
// RULE4: command 406 puts the digital outputs into forced mode.
// RULE5: command 400 returns forced outputs to normal function drive.
// RULE6: a password is set by writing the same five-digit value twice.
// RULE7: a new password starts locking only after the next power-up.
// RULE8: while locked, writes are refused until the matching password is entered.
// RULE9: after the correct password, writing zero twice clears the protection.
// RULE10: debounce time is setting times 2 ms, setting 0 to 20, default 2.
// RULE11: selector bit 8 picks contact polarity, 1 normally open, lower bits the function.
// RULE12: a changed input selector takes effect only after restart.
// RULE13: an input change is taken only after holding for the whole debounce time; the code counts unit ticks and can take it up to one unit early.
// RULE14: out-of-range writes are refused and leave the stored value.
module dpbank_top #(
    parameter int UNIT_CYCLES = dpbank_pkg::DEBOUNCE_UNIT_CYCLES
) (
    input  wire logic                         mclk,
    input  wire logic                         srst,
    input  wire logic                         power_up,
    input  wire dpbank_pkg::dpbank_write_type wreq,
    input  wire logic [11:0]                  raddr,
    input  wire logic                         di1_raw,
    output logic [15:0]                       rdata,
    output dpbank_pkg::dpbank_wresp_type      wresp,
    output logic [15:0]                       speed_integral_gain,
    output logic [15:0]                       speed_feedforward_gain,
    output logic                              outputs_forced,
    output logic                              lock_active,
    output logic                              defaults_pending,
    output logic                              di1_active,
    output logic [7:0]                        di1_function
);
    typedef enum logic [2:0] {
        PW_IDLE   = 3'b001,
        PW_REPEAT = 3'b010,
        PW_ZERO2  = 3'b100
    } dpbank_pw_type;

    logic [15:0]   special_function_ff;
    logic [15:0]   input_debounce_time_ff;
    logic [15:0]   input1_select_ff;
    logic [15:0]   input1_select_live_ff;
    logic [15:0]   prot_ff [0:9];
    logic [15:0]   password_ff;
    logic [15:0]   pw_first_ff;
    logic          pw_armed_ff;
    logic          unlocked_ff;
    dpbank_pw_type pw_state_ff;
    logic [31:0]   unit_cnt_ff;
    logic          unit_tick_ff;
    logic          di1_clean;
    logic          in_range;
    logic          is_prot;
    logic          prot_ok;
    logic [3:0]    prot_idx;
    logic          do_write;
    logic          is_pw;

    // ==========================================================
    // write decode and range check
    always_comb begin
        is_pw    = wreq.addr == dpbank_pkg::OFS_PASSWORD;
        is_prot  = 1'b0;
        prot_ok  = 1'b0;
        prot_idx = 4'h0;
        in_range = 1'b1;
        case (wreq.addr)
            dpbank_pkg::OFS_SPEED_INTEGRAL:
                in_range = wreq.data <= dpbank_pkg::MAX_SPEED_INTEGRAL; // see RULE14
            dpbank_pkg::OFS_SPEED_FEEDFWD:
                in_range = wreq.data <= dpbank_pkg::MAX_SPEED_FEEDFWD; // see RULE14
            dpbank_pkg::OFS_DEBOUNCE:
                in_range = wreq.data <= dpbank_pkg::MAX_DEBOUNCE; // see RULE10
            dpbank_pkg::OFS_INPUT1_SELECT:
                in_range = wreq.data <= dpbank_pkg::MAX_INPUT_SELECT; // see RULE14
            dpbank_pkg::OFS_SPECIAL_FUNCTION,
            dpbank_pkg::OFS_PASSWORD:
                in_range = 1'b1;
            default: begin
                if (wreq.addr >= dpbank_pkg::OFS_PROTECTED_COMM &&
                    wreq.addr <= dpbank_pkg::OFS_PROT_BLOCK_LAST && !wreq.addr[0]) begin
                    is_prot  = 1'b1;
                    prot_idx = 4'((wreq.addr - dpbank_pkg::OFS_PROTECTED_COMM) >> 1);
                    if (prot_idx == 4'h0) begin
                        prot_ok = special_function_ff == dpbank_pkg::CMD_UNLOCK_COMM; // see RULE2
                    end else begin
                        prot_ok = special_function_ff == dpbank_pkg::CMD_UNLOCK_BLOCK; // see RULE3
                    end
                end else begin
                    in_range = 1'b0;
                end
            end
        endcase
        // password port always open; the rest gated by the lock
        do_write = wreq.wr && in_range && !is_pw && (!lock_active || unlocked_ff) &&
                   (!is_prot || prot_ok); // see RULE8
    end

    // ==========================================================
    // write response
    always_ff @(posedge mclk) begin
        if (srst) begin
            wresp <= '0;
        end else begin
            wresp.accepted <= do_write || (wreq.wr && is_pw);
            wresp.refused  <= wreq.wr && !is_pw && !do_write; // see RULE8
        end
    end

    // ==========================================================
    // plain parameter storage
    always_ff @(posedge mclk) begin
        if (srst || (power_up && defaults_pending)) begin
            speed_integral_gain    <= dpbank_pkg::RST_SPEED_INTEGRAL; // see RULE1
            speed_feedforward_gain <= dpbank_pkg::RST_SPEED_FEEDFWD;
            input_debounce_time_ff <= dpbank_pkg::RST_DEBOUNCE;
            input1_select_ff       <= dpbank_pkg::RST_INPUT1_SELECT;
        end else if (do_write) begin
            case (wreq.addr)
                dpbank_pkg::OFS_SPEED_INTEGRAL: speed_integral_gain    <= wreq.data;
                dpbank_pkg::OFS_SPEED_FEEDFWD:  speed_feedforward_gain <= wreq.data;
                dpbank_pkg::OFS_DEBOUNCE:       input_debounce_time_ff <= wreq.data;
                dpbank_pkg::OFS_INPUT1_SELECT:  input1_select_ff       <= wreq.data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // protected communication parameters
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_prot
            always_ff @(posedge mclk) begin
                if (srst || (power_up && defaults_pending)) begin
                    prot_ff[gi] <= dpbank_pkg::RST_PROTECTED;
                end else if (do_write && is_prot && prot_idx == 4'(gi)) begin
                    prot_ff[gi] <= wreq.data; // see RULE2 RULE3
                end
            end
        end
    endgenerate

    // ==========================================================
    // command word and its side effects
    always_ff @(posedge mclk) begin
        if (srst) begin
            special_function_ff <= dpbank_pkg::RST_SPECIAL_FUNC;
            outputs_forced      <= 1'b0;
            defaults_pending    <= 1'b0;
        end else begin
            if (power_up) begin
                defaults_pending    <= 1'b0; // restore applied now, see RULE1
                special_function_ff <= dpbank_pkg::RST_SPECIAL_FUNC;
            end
            if (do_write && wreq.addr == dpbank_pkg::OFS_SPECIAL_FUNCTION) begin
                special_function_ff <= wreq.data;
                case (wreq.data)
                    dpbank_pkg::CMD_PARAM_RESET:   defaults_pending <= 1'b1; // see RULE1
                    dpbank_pkg::CMD_FORCE_OUTPUTS: outputs_forced   <= 1'b1; // see RULE4
                    dpbank_pkg::CMD_NORMAL_OUTPUT: begin
                        if (outputs_forced) begin
                            outputs_forced <= 1'b0; // see RULE5
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // password entry sequencer
    always_ff @(posedge mclk) begin
        if (srst) begin
            pw_state_ff <= PW_IDLE;
            password_ff <= 16'h0000;
            pw_first_ff <= 16'h0000;
            pw_armed_ff <= 1'b0;
            unlocked_ff <= 1'b0;
            lock_active <= 1'b0;
        end else if (power_up) begin
            pw_state_ff <= PW_IDLE;
            lock_active <= password_ff != 16'h0000; // lock starts here, see RULE7
            unlocked_ff <= 1'b0;
        end else if (wreq.wr && is_pw) begin
            case (pw_state_ff)
                PW_IDLE: begin
                    if (lock_active && !unlocked_ff) begin
                        unlocked_ff <= wreq.data == password_ff; // see RULE8
                    end else if (lock_active && wreq.data == 16'h0000) begin
                        pw_state_ff <= PW_ZERO2; // first zero, see RULE9
                    end else if (wreq.data != 16'h0000) begin
                        pw_first_ff <= wreq.data; // five-digit entry, see RULE6
                        pw_state_ff <= PW_REPEAT;
                    end
                end
                PW_REPEAT: begin
                    if (wreq.data == pw_first_ff) begin
                        password_ff <= wreq.data; // stored, not yet locking, see RULE7
                        pw_armed_ff <= 1'b1;
                    end
                    pw_state_ff <= PW_IDLE; // see RULE6
                end
                PW_ZERO2: begin
                    if (wreq.data == 16'h0000) begin
                        password_ff <= 16'h0000; // see RULE9
                        pw_armed_ff <= 1'b0;
                        lock_active <= 1'b0;
                    end
                    pw_state_ff <= PW_IDLE;
                end
                default: pw_state_ff <= PW_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read mux
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= 16'h0000;
        end else begin
            case (raddr)
                dpbank_pkg::OFS_SPEED_INTEGRAL:   rdata <= speed_integral_gain;
                dpbank_pkg::OFS_SPEED_FEEDFWD:    rdata <= speed_feedforward_gain;
                dpbank_pkg::OFS_SPECIAL_FUNCTION: rdata <= special_function_ff;
                dpbank_pkg::OFS_DEBOUNCE:         rdata <= input_debounce_time_ff;
                dpbank_pkg::OFS_INPUT1_SELECT:    rdata <= input1_select_ff;
                dpbank_pkg::OFS_PASSWORD:
                    rdata <= {13'h0000, pw_armed_ff, unlocked_ff, lock_active};
                default: begin
                    if (raddr >= dpbank_pkg::OFS_PROTECTED_COMM &&
                        raddr <= dpbank_pkg::OFS_PROT_BLOCK_LAST && !raddr[0]) begin
                        rdata <= prot_ff[4'((raddr - dpbank_pkg::OFS_PROTECTED_COMM) >> 1)];
                    end else begin
                        rdata <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // 2 ms unit tick divider
    always_ff @(posedge mclk) begin
        if (srst || unit_cnt_ff == 32'(UNIT_CYCLES - 1)) begin
            unit_cnt_ff  <= 32'h00000000;
            unit_tick_ff <= !srst; // see RULE10
        end else begin
            unit_cnt_ff  <= unit_cnt_ff + 32'h00000001;
            unit_tick_ff <= 1'b0;
        end
    end

    // ==========================================================
    // live input mapping, latched at restart
    always_ff @(posedge mclk) begin
        if (srst) begin
            input1_select_live_ff <= dpbank_pkg::RST_INPUT1_SELECT;
        end else if (power_up) begin
            input1_select_live_ff <= defaults_pending ? dpbank_pkg::RST_INPUT1_SELECT
                                                      : input1_select_ff; // see RULE12
        end
    end

    dpbank_debounce #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_debounce (
        .mclk           (mclk),
        .srst           (srst),
        .unit_tick      (unit_tick_ff),
        .debounce_units (input_debounce_time_ff),
        .raw_in         (di1_raw),
        .clean_out      (di1_clean)
    );

    // contact polarity and function code
    always_ff @(posedge mclk) begin
        if (srst) begin
            di1_active   <= 1'b0;
            di1_function <= 8'h00;
        end else begin
            di1_active   <= input1_select_live_ff[dpbank_pkg::SEL_POLARITY_BIT] ?
                            di1_clean : !di1_clean; // see RULE11
            di1_function <= input1_select_live_ff[dpbank_pkg::SEL_FUNC_MSB:0]; // see RULE11
        end
    end
endmodule
`default_nettype wire

// file: tb/dpbank_host.sv
// host model issuing parameter writes as keypad or link traffic
`timescale 1ns/1ns
`default_nettype none
module dpbank_host (
    input  wire logic                        mclk,
    output var dpbank_pkg::dpbank_write_type wreq
);
    initial wreq = '0;

    // ==========================================================
    // one write held for one edge, released fields show inverse
    task automatic put(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        wreq <= '{wr: 1'b1, addr: a, data: d};
        @(posedge mclk);
        wreq <= '{wr: 1'b0, addr: ~a, data: ~d};
    endtask

    // same value entered twice, for password setup or clearing
    task automatic twice(input logic [11:0] a, input logic [15:0] d);
        put(a, d);
        put(a, d);
    endtask
endmodule
`default_nettype wire

// file: tb/dpbank_sva.sv
// assertion checker watching the drive parameter bank ports
`timescale 1ns/1ns
`default_nettype none
module dpbank_sva #(
    parameter int UNIT_CYCLES = 4
) (
    input wire logic                         mclk,
    input wire logic                         srst,
    input wire logic                         power_up,
    input wire dpbank_pkg::dpbank_write_type wreq,
    input wire logic [11:0]                  raddr,
    input wire logic                         di1_raw,
    input wire logic [15:0]                  rdata,
    input wire dpbank_pkg::dpbank_wresp_type wresp,
    input wire logic [15:0]                  speed_integral_gain,
    input wire logic [15:0]                  speed_feedforward_gain,
    input wire logic                         outputs_forced,
    input wire logic                         lock_active,
    input wire logic                         defaults_pending,
    input wire logic                         di1_active,
    input wire logic [7:0]                   di1_function
);
    // ==========================================================
    // one clock domain, reset disables every check
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    resp_follows_a: assert property (wreq.wr |=> wresp.accepted ^ wresp.refused)
        else $error("write without a single answer");
    resp_idle_a: assert property (!wreq.wr |=> !(wresp.accepted || wresp.refused))
        else $error("answer without a write");
    range_refuse_a: assert property (wreq.wr && wreq.addr == 12'h20c && wreq.data > 16'h03ff
        |=> wresp.refused && $stable(speed_integral_gain)) else $error("out of range gain taken");
    gain_load_a: assert property (wresp.accepted && $past(wreq.addr) == 12'h20c
        |-> speed_integral_gain == $past(wreq.data)) else $error("accepted gain not stored");
    force_on_a: assert property (wreq.wr && !lock_active && wreq.addr == 12'h210
        && wreq.data == 16'h0196 |=> outputs_forced) else $error("forced mode not entered");
    force_off_a: assert property (wreq.wr && !lock_active && wreq.addr == 12'h210
        && wreq.data == 16'h0190 |=> !outputs_forced) else $error("forced mode not left");
    reset_arm_a: assert property (wreq.wr && !lock_active && wreq.addr == 12'h210
        && wreq.data == 16'h000a |=> defaults_pending) else $error("restore not armed");
    reset_apply_a: assert property (power_up && defaults_pending |=> !defaults_pending
        && speed_integral_gain == 16'h0064 && speed_feedforward_gain == 16'h0000)
        else $error("defaults not restored");
    lock_rise_a: assert property ($rose(lock_active) |-> $past(power_up))
        else $error("lock engaged without restart");
    sel_hold_a: assert property ($changed(di1_function) |-> $past(power_up, 2) || $past(srst, 2))
        else $error("selector changed without restart");
endmodule
bind dpbank_top dpbank_sva #(.UNIT_CYCLES(UNIT_CYCLES)) i_dpbank_sva (
    .mclk(mclk), .srst(srst), .power_up(power_up), .wreq(wreq), .raddr(raddr),
    .di1_raw(di1_raw), .rdata(rdata), .wresp(wresp), .speed_integral_gain(speed_integral_gain),
    .speed_feedforward_gain(speed_feedforward_gain), .outputs_forced(outputs_forced),
    .lock_active(lock_active), .defaults_pending(defaults_pending),
    .di1_active(di1_active), .di1_function(di1_function));
`default_nettype wire

// file: tb/tb_drive_param_bank_with_unlock.sv
// self-checking bench for the drive parameter bank
`timescale 1ns/1ns
`default_nettype none
module tb_drive_param_bank_with_unlock;
    logic                         mclk = 1'b0;
    logic                         srst = 1'b1;
    logic                         power_up = 1'b0;
    logic [11:0]                  raddr = 12'h000;
    logic                         di1_raw = 1'b0;
    dpbank_pkg::dpbank_write_type wreq;
    dpbank_pkg::dpbank_wresp_type wresp;
    logic [15:0]                  rdata, gain_i, gain_f;
    logic                         forced, locked, pending, di1_act;
    logic [7:0]                   di1_fn;
    int                           errors = 0;
    int                           n_checks = 0;
    int                           mdl[int];
    int                           cmd, i;
    bit                           lk, unl, pend, pwset;

    // ==========================================================
    // clock, host model and design
    always #2 mclk = ~mclk;
    dpbank_host i_dpbank_host (.mclk(mclk), .wreq(wreq));
    dpbank_top #(.UNIT_CYCLES(4)) i_dpbank_top (
        .mclk(mclk), .srst(srst), .power_up(power_up), .wreq(wreq), .raddr(raddr),
        .di1_raw(di1_raw), .rdata(rdata), .wresp(wresp), .speed_integral_gain(gain_i),
        .speed_feedforward_gain(gain_f), .outputs_forced(forced), .lock_active(locked),
        .defaults_pending(pending), .di1_active(di1_act), .di1_function(di1_fn));

    // ==========================================================
    // compare, verdict and reference model
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic defaults();
        mdl[12'h20c] = 100;
        mdl[12'h20e] = 0;
        mdl[12'h212] = 2;
        mdl[12'h214] = 12'h101;
        for (int k = 12'h414; k <= 12'h426; k += 2) mdl[k] = 0;
    endtask

    function automatic logic exp_ok(input logic [11:0] a, input logic [15:0] d);
        if (a == 12'h500) return 1'b1;
        if (lk && !unl) return 1'b0;
        case (a)
            12'h20c: return d <= 16'h03ff;
            12'h20e: return d <= 16'h0064;
            12'h210: return 1'b1;
            12'h212: return d <= 16'h0014;
            12'h214: return d <= 16'h015f;
            12'h414: return cmd == 20;
            default: return a >= 12'h416 && a <= 12'h426 && !a[0] && cmd == 22;
        endcase
    endfunction

    // one write, answer and stored values compared with the model
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic ok;
        ok = exp_ok(a, d);
        i_dpbank_host.put(a, d);
        @(posedge mclk);
        chk("accepted", 16'(wresp.accepted), 16'(ok));
        chk("refused", 16'(wresp.refused), 16'(!ok));
        if (ok) mdl[a] = d;
        if (ok && a == 12'h210) cmd = d;
        chk("integral_gain", gain_i, 16'(mdl[12'h20c]));
        chk("feedfwd_gain", gain_f, 16'(mdl[12'h20e]));
        if (a != 12'h500 && mdl.exists(a)) begin
            raddr <= a;
            repeat (2) @(posedge mclk);
            chk("rdata", rdata, 16'(mdl[a]));
        end
    endtask

    // restart pulse, model applies pending defaults and lock
    task automatic pwr();
        @(posedge mclk);
        power_up <= 1'b1;
        @(posedge mclk);
        power_up <= 1'b0;
        // live selector reaches the function output one edge after the restart
        repeat (2) @(posedge mclk);
        cmd = 0;
        mdl[12'h210] = 0;
        if (pend) defaults();
        pend = 0;
        lk = pwset;
        unl = 0;
        chk("integral_gain", gain_i, 16'(mdl[12'h20c]));
        chk("pending", 16'(pending), 16'h0000);
    endtask

    // ==========================================================
    // watchdog
    initial begin
        #80000;
        errors++;
        close_out();
    end

    // main sequence
    initial begin
        i = $urandom(32'h4ade);
        defaults();
        mdl[12'h210] = 0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        for (i = 0; i < 12; i++) begin
            wr(12'h20c, 16'($urandom % 1400));
            wr(12'h20e, 16'($urandom % 130));
        end
        wr(12'h20c, 16'h03ff);
        wr(12'h20c, 16'h0400);
        wr(12'h20d, 16'h0001);
        wr(12'h414, 16'h0007);
        wr(12'h210, 16'h0014);
        wr(12'h414, 16'h0007);
        wr(12'h416, 16'h0003);
        wr(12'h210, 16'h0016);
        for (i = 0; i < 10; i++) wr(12'(12'h416 + 2 * i), 16'(i + 1));
        wr(12'h414, 16'h0009);
        wr(12'h210, 16'h0190);
        chk("forced", 16'(forced), 16'h0000);
        wr(12'h210, 16'h0196);
        chk("forced", 16'(forced), 16'h0001);
        wr(12'h210, 16'h0190);
        chk("forced", 16'(forced), 16'h0000);
        wr(12'h212, 16'h0015);
        wr(12'h212, 16'h0003);
        di1_raw <= 1'b1;
        repeat (3) @(posedge mclk);
        di1_raw <= 1'b0;
        repeat (20) @(posedge mclk);
        chk("di1_short", 16'(di1_act), 16'h0000);
        di1_raw <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("di1_early", 16'(di1_act), 16'h0000);
        for (i = 0; i < 20 && di1_act !== 1'b1; i++) @(posedge mclk);
        chk("di1_held", 16'(di1_act), 16'h0001);
        wr(12'h214, 16'h0160);
        wr(12'h214, 16'h0005);
        chk("di1_function", 16'(di1_fn), 16'h0001);
        pwr();
        chk("di1_function", 16'(di1_fn), 16'h0005);
        repeat (20) @(posedge mclk);
        chk("di1_closed", 16'(di1_act), 16'h0000);
        wr(12'h210, 16'h000a);
        chk("pending", 16'(pending), 16'h0001);
        pend = 1;
        pwr();
        i_dpbank_host.twice(12'h500, 16'd12345);
        @(posedge mclk);
        chk("pw_accepted", 16'(wresp.accepted), 16'h0001);
        wr(12'h20c, 16'h0011);
        chk("locked", 16'(locked), 16'h0000);
        pwset = 1;
        pwr();
        chk("locked", 16'(locked), 16'h0001);
        wr(12'h20c, 16'h0022);
        wr(12'h500, 16'd12344);
        wr(12'h20e, 16'h0005);
        wr(12'h500, 16'd12345);
        unl = 1;
        wr(12'h20c, 16'h0033);
        i_dpbank_host.twice(12'h500, 16'h0000);
        @(posedge mclk);
        pwset = 0;
        pwr();
        chk("locked", 16'(locked), 16'h0000);
        wr(12'h20c, 16'h0044);
        close_out();
    end
endmodule
`default_nettype wire
